// ### src/modem_cca_sync_config.sv
// Modem configuration, strength estimate and clear-channel bank on AHB-Lite
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ns
module modem_cca_sync_config
  import modem_cfg_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [4:0]  correlator_value,
  input  wire logic        rx_enabled,
  input  wire logic        symbol_tick,
  input  wire logic [7:0]  power_sample,
  input  wire logic        rx_sym_valid,
  input  wire logic [3:0]  rx_sym,
  input  wire logic        tx_start,
  input  wire logic        tx_sym_ack,
  output logic             corr_search_enable,
  output logic             offset_filter_lock,
  output logic             phase_reverse,
  output logic             tx_from_buffer,
  output logic             tx_from_serial,
  output logic             tx_buffer_loop,
  output logic             tx_from_random,
  output logic             tx_endless,
  output logic             rx_to_buffer,
  output logic             rx_to_pins,
  output logic             rx_buffer_loop,
  output logic             rx_endless,
  output logic             clear_channel,
  output logic [3:0]       tx_sym,
  output logic             tx_sym_valid,
  output logic             tx_sync_done,
  output logic             sync_found
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [10:0]     ctrl1;
    logic [7:0]      clear_channel_threshold;
    logic [15:0]     sync;
    logic [3:0]      pre_len;
    logic            dp_wr;
    logic [7:0]      dp_idx;
    logic [31:0]     rdata;
    logic [7:0][7:0] hist;
    logic [3:0]      sym_cnt;
    logic [7:0]      est;
    logic            est_valid;
    logic            cca;
    logic            search_en;
    logic [3:0]      mode_out;
  } bank_t;

  bank_t st_reg, st_next;

  logic              take;
  logic [7:0][7:0]   hist_new;
  logic signed [10:0] sum;
  logic [4:0]        correlator_threshold;
  tx_src_t           tx_src;
  rx_sink_t          rx_sink;

  assign take     = hsel && htrans[1] && hready;
  assign hist_new = {st_reg.hist[6:0], power_sample};
  assign correlator_threshold = st_reg.ctrl1[CORR_LSB +: CORR_W];
  assign tx_src   = tx_src_t'(st_reg.ctrl1[TXSRC_LSB +: 2]);
  assign rx_sink  = rx_sink_t'(st_reg.ctrl1[RXSINK_LSB +: 2]);

  // ----------------------------------------------------------------
  // Averaging adder
  // ----------------------------------------------------------------
  always_comb begin
    sum = '0;
    for (int i = 0; i < AVG_SYMBOLS; i++) begin
      sum = sum + 11'($signed(hist_new[i])); // RULE_15
    end
  end

  // Read view built from next state, so a read right after a write sees it
  function automatic logic [31:0] read_mux(input bank_t s, input logic [7:0] idx);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (idx)
      IDX_CTRL1:    r[10:0] = s.ctrl1; // RULE_01
      IDX_STRENGTH: r[15:0] = {s.clear_channel_threshold, s.est}; // RULE_14
      IDX_SYNC:     r[15:0] = s.sync;
      IDX_AUX: begin
        r[3:0]       = s.pre_len;
        r[VALID_BIT] = s.est_valid;
        r[CCA_BIT]   = s.cca;
      end
      default:      r = 32'h0000_0000;
    endcase
    return r;
  endfunction : read_mux

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;

    // Data phase of a write; reserved bits dropped
    if (st_reg.dp_wr) begin
      case (st_reg.dp_idx)
        IDX_CTRL1:    st_next.ctrl1   = hwdata[10:0]; // RULE_01
        IDX_STRENGTH: st_next.clear_channel_threshold = hwdata[THR_LSB +: 8]; // RULE_12
        IDX_SYNC:     st_next.sync    = hwdata[15:0]; // RULE_18
        IDX_AUX:      st_next.pre_len = hwdata[3:0];
        default: ;
      endcase
    end

    // Strength estimate
    if (!rx_enabled) begin
      st_next.sym_cnt   = 4'd0;
      st_next.est       = EST_INVALID; // RULE_17
      st_next.est_valid = 1'b0;
    end else if (symbol_tick) begin
      st_next.hist = hist_new;
      if (st_reg.sym_cnt != AVG_COUNT) begin
        st_next.sym_cnt = st_reg.sym_cnt + 4'd1;
      end
      if (st_reg.sym_cnt >= AVG_COUNT - 4'd1) begin
        st_next.est       = sum[10:3]; // RULE_15
        st_next.est_valid = 1'b1; // RULE_16
      end
    end

    // Signed compare; invalid estimate reads as very weak signal
    st_next.cca = $signed(st_reg.est) < $signed(st_reg.clear_channel_threshold); // RULE_13
    st_next.search_en = correlator_value > correlator_threshold; // RULE_02

    st_next.mode_out = {st_reg.ctrl1[PHASE_BIT], ~st_reg.ctrl1[AVG_BIT], 2'b00}; // RULE_03

    // Address phase; reads have no side effects
    st_next.dp_wr  = take && hwrite;
    st_next.dp_idx = haddr[9:2];
    st_next.rdata  = (take && !hwrite) ? read_mux(st_next, haddr[9:2]) : 32'h0; // RULE_24
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_reg           <= '0;
      st_reg.ctrl1     <= RST_CTRL1;
      st_reg.clear_channel_threshold   <= RST_CLEAR_CHANNEL_THRESHOLD; // RULE_12
      st_reg.sync      <= RST_SYNC; // RULE_18
      st_reg.pre_len   <= RST_PRE_LEN;
      st_reg.est       <= EST_INVALID; // RULE_17
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Bus answer: zero wait states, always OKAY
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_reg.rdata;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  assign corr_search_enable = st_reg.search_en;
  assign offset_filter_lock = st_reg.mode_out[2]; // RULE_03
  assign phase_reverse      = st_reg.mode_out[3]; // RULE_04

  assign tx_from_buffer = (tx_src == TX_BUFFERED); // RULE_05
  assign tx_from_serial = (tx_src == TX_SERIAL); // RULE_06
  assign tx_buffer_loop = (tx_src == TX_LOOP); // RULE_07
  assign tx_from_random = (tx_src == TX_RANDOM); // RULE_08
  assign tx_endless     = (tx_src != TX_BUFFERED);

  // Reserved sink code enables nothing
  assign rx_to_buffer   = (rx_sink == RX_BUFFERED); // RULE_09
  assign rx_to_pins     = (rx_sink == RX_PINS); // RULE_10
  assign rx_buffer_loop = (rx_sink == RX_LOOP); // RULE_11
  assign rx_endless     = rx_to_pins || rx_buffer_loop;

  assign clear_channel = st_reg.cca; // RULE_13

  // ----------------------------------------------------------------
  // Sync pattern sequencer
  // ----------------------------------------------------------------
  sync_nibble_unit u_sync (
    .ref_clk      (ref_clk),
    .srst         (srst),
    .pattern      (st_reg.sync),
    .pre_len      (st_reg.pre_len),
    .tx_start     (tx_start),
    .tx_sym_ack   (tx_sym_ack),
    .search_en    (st_reg.search_en),
    .rx_sym_valid (rx_sym_valid),
    .rx_sym       (rx_sym),
    .tx_sym       (tx_sym),
    .tx_sym_valid (tx_sym_valid),
    .tx_sync_done (tx_sync_done),
    .sync_found   (sync_found)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_corr_gate;
    @(posedge ref_clk) disable iff (srst)
    corr_search_enable |-> $past(correlator_value) > $past(correlator_threshold);
  endproperty
  a_corr_gate: assert property (p_corr_gate) // RULE_02
    else $error("Search enabled below correlator threshold");

  property p_avg_mode;
    @(posedge ref_clk) disable iff (srst)
    (st_reg.dp_wr && st_reg.dp_idx == IDX_CTRL1) |=> ##1
      (offset_filter_lock == !$past(hwdata[AVG_BIT], 2));
  endproperty
  a_avg_mode: assert property (p_avg_mode) // RULE_03
    else $error("Offset filter mode does not follow write");

  property p_phase;
    @(posedge ref_clk) disable iff (srst)
    (st_reg.dp_wr && st_reg.dp_idx == IDX_CTRL1) |=> ##1
      (phase_reverse == $past(hwdata[PHASE_BIT], 2));
  endproperty
  a_phase: assert property (p_phase) // RULE_04
    else $error("Phase polarity does not follow write");

  property p_tx_onehot;
    @(posedge ref_clk) disable iff (srst)
    $onehot({tx_from_buffer, tx_from_serial, tx_buffer_loop, tx_from_random})
      && (tx_endless == !tx_from_buffer);
  endproperty
  a_tx_onehot: assert property (p_tx_onehot) // RULE_05 RULE_06 RULE_07 RULE_08
    else $error("Transmit source decode broken");

  property p_rx_sink;
    @(posedge ref_clk) disable iff (srst)
    (rx_sink == RX_RSVD) |-> !(rx_to_buffer || rx_to_pins || rx_buffer_loop);
  endproperty
  a_rx_sink: assert property (p_rx_sink) // RULE_09 RULE_10 RULE_11
    else $error("Reserved receive sink enabled a path");

  property p_cca;
    @(posedge ref_clk) disable iff (srst)
    !srst |=> (clear_channel == ($signed($past(st_reg.est)) < $signed($past(st_reg.clear_channel_threshold))));
  endproperty
  a_cca: assert property (p_cca) // RULE_13
    else $error("Clear-channel level wrong");

  property p_valid_rise;
    @(posedge ref_clk) disable iff (srst)
    $rose(st_reg.est_valid) |-> $past(st_reg.sym_cnt) == 4'd7 && $past(symbol_tick)
      && $past(rx_enabled);
  endproperty
  a_valid_rise: assert property (p_valid_rise) // RULE_16
    else $error("Strength valid before eight symbols");

  property p_invalid;
    @(posedge ref_clk) disable iff (srst)
    !rx_enabled |=> (st_reg.est == EST_INVALID) && !st_reg.est_valid;
  endproperty
  a_invalid: assert property (p_invalid) // RULE_17
    else $error("Estimate not invalid while receiver off");

  property p_sync_reset;
    @(posedge ref_clk) disable iff (srst)
    $past(srst) |-> (st_reg.sync == RST_SYNC) && (st_reg.clear_channel_threshold == RST_CLEAR_CHANNEL_THRESHOLD);
  endproperty
  a_sync_reset: assert property (p_sync_reset) // RULE_18 RULE_12
    else $error("Reset values wrong");

endmodule : modem_cca_sync_config

// ### src/modem_cfg_pkg.sv
// Register map, field layout and mode encodings of the modem configuration bank
// Functional notes
// RULE_01: Host writes zeros to reserved control bits
// RULE_02: Correlator above threshold before delimiter search
// RULE_03: Offset filter bit selects lock or update
// RULE_04: Phase bit reverses modulation for both directions
// RULE_05: Transmit source 0 uses transmit buffer
// RULE_06: Transmit source 1 streams serial data endlessly
// RULE_07: Transmit source 2 loops buffer, ignores underflow
// RULE_08: Transmit source 3 sends pseudo-random data endlessly
// RULE_09: Receive sink 0 fills buffer; 3 reserved
// RULE_10: Receive sink 1 drives pins, endless reception
// RULE_11: Receive sink 2 loops buffer, ignores overflow
// RULE_12: Clear-channel threshold signed byte, reset -32
// RULE_13: Clear-channel high when signal below threshold
// RULE_14: Read-only signed strength estimate, low byte
// RULE_15: Estimate averaged over eight symbol periods
// RULE_16: Valid bit after eight enabled symbol periods
// RULE_17: Estimate resets to -128, meaning invalid
// RULE_18: Sync pattern writable, resets to 0xa70f
// RULE_19: Pattern handled nibble-wise, least significant first
// RULE_20: Transmitted all-ones nibbles become zero symbols
// RULE_21: All-ones nibbles are wildcards on receive
// RULE_22: Implicit zero precedes first required symbol
// RULE_23: Preamble bytes of two zero symbols first
// RULE_24: Sixteen-bit registers, whole words, side-effect-free reads
package modem_cfg_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_CTRL1    = 8'h12;
  localparam logic [7:0]  IDX_STRENGTH = 8'h13;
  localparam logic [7:0]  IDX_SYNC     = 8'h14;
  localparam logic [7:0]  IDX_AUX      = 8'h18;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [10:0] RST_CTRL1    = 11'h000;
  localparam logic [7:0]  RST_CLEAR_CHANNEL_THRESHOLD  = 8'he0;
  localparam logic [15:0] RST_SYNC     = 16'ha70f;
  localparam logic [3:0]  RST_PRE_LEN  = 4'h2;
  localparam logic [7:0]  EST_INVALID  = 8'h80;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CORR_LSB   = 6;
  localparam int CORR_W     = 5;
  localparam int AVG_BIT    = 5;
  localparam int PHASE_BIT  = 4;
  localparam int TXSRC_LSB  = 2;
  localparam int RXSINK_LSB = 0;
  localparam int THR_LSB    = 8;
  localparam int VALID_BIT  = 8;
  localparam int CCA_BIT    = 9;

  // ----------------------------------------------------------------
  // Averaging
  // ----------------------------------------------------------------
  localparam int         AVG_SYMBOLS = 8;
  localparam logic [3:0] AVG_COUNT   = 4'd8;

  typedef enum logic [1:0] {
    TX_BUFFERED = 2'b00,
    TX_SERIAL   = 2'b01,
    TX_LOOP     = 2'b10,
    TX_RANDOM   = 2'b11
  } tx_src_t;

  typedef enum logic [1:0] {
    RX_BUFFERED = 2'b00,
    RX_PINS     = 2'b01,
    RX_LOOP     = 2'b10,
    RX_RSVD     = 2'b11
  } rx_sink_t;

  typedef enum logic [1:0] {
    TS_IDLE     = 2'b00,
    TS_PREAMBLE = 2'b01,
    TS_SYNC     = 2'b10
  } tx_seq_t;

endpackage : modem_cfg_pkg

// ### src/sync_nibble_unit.sv
// Preamble and sync pattern symbol sequencer plus receive sync detector
`timescale 1ns/1ns
module sync_nibble_unit
  import modem_cfg_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic [15:0] pattern,
  input  wire logic [3:0]  pre_len,
  input  wire logic        tx_start,
  input  wire logic        tx_sym_ack,
  input  wire logic        search_en,
  input  wire logic        rx_sym_valid,
  input  wire logic [3:0]  rx_sym,
  output logic [3:0]       tx_sym,
  output logic             tx_sym_valid,
  output logic             tx_sync_done,
  output logic             sync_found
);

  typedef struct packed {
    tx_seq_t         state;
    logic [4:0]      cnt;
    logic [3:0]      sym;
    logic            vld;
    logic            done;
    logic [4:0][3:0] hist;
    logic            found;
  } seq_t;

  seq_t st_reg, st_next;
  logic [4:0][3:0] hist_new;

  function automatic logic [3:0] tx_nib(input logic [15:0] p, input logic [1:0] i);
    logic [3:0] n;
    n = p[i*4 +: 4];
    return (n == 4'hf) ? 4'h0 : n; // RULE_20
  endfunction : tx_nib

  // Newest symbol sits at index 0
  function automatic logic sync_match(input logic [15:0] p, input logic [4:0][3:0] h);
    logic ok;
    logic seen;
    ok   = 1'b1;
    seen = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (p[i*4 +: 4] != 4'hf) begin // RULE_21
        if (h[3-i] != p[i*4 +: 4]) ok = 1'b0;
        if (!seen && h[4-i] != 4'h0) ok = 1'b0; // RULE_22
        seen = 1'b1;
      end
    end
    return ok;
  endfunction : sync_match

  assign hist_new = {st_reg.hist[3:0], rx_sym};

  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    unique case (st_reg.state)
      TS_IDLE: begin
        if (tx_start) begin
          st_next.state = TS_PREAMBLE; // RULE_23
          st_next.cnt   = 5'd0;
          st_next.sym   = 4'h0;
          st_next.vld   = 1'b1;
        end
      end
      TS_PREAMBLE: begin
        if (tx_sym_ack) begin
          // Two zero symbols per preamble byte, length plus one bytes
          if (st_reg.cnt == {pre_len, 1'b1}) begin // RULE_23
            st_next.state = TS_SYNC;
            st_next.cnt   = 5'd0;
            st_next.sym   = tx_nib(pattern, 2'd0); // RULE_19
          end else begin
            st_next.cnt = st_reg.cnt + 5'd1;
          end
        end
      end
      TS_SYNC: begin
        if (tx_sym_ack) begin
          if (st_reg.cnt == 5'd3) begin
            st_next.state = TS_IDLE;
            st_next.vld   = 1'b0;
            st_next.done  = 1'b1;
          end else begin
            st_next.cnt = st_reg.cnt + 5'd1;
            st_next.sym = tx_nib(pattern, st_reg.cnt[1:0] + 2'd1); // RULE_19
          end
        end
      end
      default: begin
        st_next.state = TS_IDLE;
        st_next.vld   = 1'b0;
      end
    endcase
    st_next.found = 1'b0;
    if (rx_sym_valid) begin
      st_next.hist  = hist_new;
      st_next.found = search_en && sync_match(pattern, hist_new); // RULE_02
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tx_sym       = st_reg.sym;
  assign tx_sym_valid = st_reg.vld;
  assign tx_sync_done = st_reg.done;
  assign sync_found   = st_reg.found;

  property p_no_ones_sent;
    @(posedge ref_clk) disable iff (srst)
    (st_reg.state == TS_SYNC) |-> (tx_sym != 4'hf);
  endproperty
  a_no_ones_sent: assert property (p_no_ones_sent) // RULE_20
    else $error("All-ones nibble transmitted");

  property p_found_gated;
    @(posedge ref_clk) disable iff (srst)
    sync_found |-> $past(search_en) && $past(rx_sym_valid);
  endproperty
  a_found_gated: assert property (p_found_gated) // RULE_02
    else $error("Sync declared without correlator gate");

endmodule : sync_nibble_unit

// ### testbench/modem_cca_sync_config_test.sv
// Self-checking bench for the modem configuration, strength and sync bank
`timescale 1ns/1ns
module modem_cca_sync_config_test
  import modem_cfg_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  wire logic   hready;
  logic        hreadyout, hresp;
  logic [31:0] hrdata;
  logic [4:0]  correlator_value = 5'h0;
  logic        rx_enabled = 1'b0;
  logic        symbol_tick = 1'b0;
  logic [7:0]  power_sample = 8'h0;
  logic        tx_start = 1'b0;
  logic        slow = 1'b0;
  logic        rx_sym_valid, tx_sym_ack, tx_sym_valid, tx_sync_done, sync_found;
  logic [3:0]  rx_sym, tx_sym;
  logic        corr_search_enable, offset_filter_lock, phase_reverse, clear_channel;
  logic        tx_from_buffer, tx_from_serial, tx_buffer_loop, tx_from_random, tx_endless;
  logic        rx_to_buffer, rx_to_pins, rx_buffer_loop, rx_endless;
  wire logic [10:0] modes = {offset_filter_lock, phase_reverse, tx_from_buffer, tx_from_serial,
    tx_buffer_loop, tx_from_random, tx_endless, rx_to_buffer, rx_to_pins, rx_buffer_loop,
    rx_endless};
  int          fails = 0;
  int          checked = 0;
  int          seed = 32'hfdec;
  int          n_sync = 0;
  int          n_done = 0;

  assign hready = hreadyout;
  always #25 ref_clk = ~ref_clk;

  modem_cca_sync_config dut (.*);
  modem_side_model partner (.*);

  always @(posedge ref_clk) begin
    if (sync_found === 1'b1) n_sync++;
    if (tx_sync_done === 1'b1) n_done++;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [10:0] exp_modes(input logic [15:0] c);
    logic [1:0] t;
    logic [1:0] r;
    t = c[3:2];
    r = c[1:0];
    return {~c[5], c[4], t == 2'd0, t == 2'd1, t == 2'd2, t == 2'd3, t != 2'd0,
      r == 2'd0, r == 2'd1, r == 2'd2, r == 2'd1 || r == 2'd2};
  endfunction : exp_modes

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  // Zero-wait slave, but the master still waits on hready, bounded
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (hready !== 1'b1 && n < 50);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge ref_clk); n++; end while (hready !== 1'b1 && n < 100);
    rd = hrdata;
    chk("hresp", hresp, 32'h0);
    if (n >= 50) begin
      fails++;
      tally_and_finish();
    end
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    logic [31:0] x;
    bus(1'b1, idx, {16'h0, d}, x);
  endtask : wr

  task automatic rchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, idx, 32'h0, d);
    chk(what, d, exp);
  endtask : rchk

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] c;
    logic [31:0] d;
    logic [7:0]  e;
    logic [3:0]  pl;
    logic [3:0]  nib;
    logic [3:0]  q[$];
    logic [19:0] seqs[4];
    int          n;
    int          v;
    int          s;
    seqs = '{20'h5007a, 20'h0507a, 20'h5017a, 20'ha7050};
    cyc(8);
    srst <= 1'b0;
    cyc(2);
    rchk("ctrl reset", IDX_CTRL1, 32'h0);
    rchk("strength reset", IDX_STRENGTH, 32'h0000e080);
    rchk("sync reset", IDX_SYNC, 32'h0000a70f);
    rchk("unmapped", 8'h20, 32'h0);
    chk("clear channel", clear_channel, 32'h1);
    chk("modes", modes, exp_modes(16'h0));
    $display("reset test done");
    for (int i = 0; i < 16; i++) begin
      c = {5'h0, 5'd20, 1'($random(seed)), 1'($random(seed)), i[3:0]};
      wr(IDX_CTRL1, c);
      cyc(2);
      chk("modes", modes, exp_modes(c));
      rchk("ctrl readback", IDX_CTRL1, {16'h0, c});
    end
    wr(IDX_CTRL1, {5'h0, 5'd20, 6'h0});
    correlator_value <= 5'd20;
    cyc(3);
    chk("search at threshold", corr_search_enable, 32'h0);
    correlator_value <= 5'd21;
    cyc(3);
    chk("search above threshold", corr_search_enable, 32'h1);
    $display("mode test done");
    rx_enabled <= 1'b1;
    s = 0;
    for (int k = 0; k < 8; k++) begin
      v = $random(seed) % 100;
      s += v;
      power_sample <= v[7:0];
      symbol_tick  <= 1'b1;
      cyc(1);
      symbol_tick  <= 1'b0;
      cyc(1);
      if (k == 6) begin
        bus(1'b0, IDX_AUX, 32'h0, d);
        chk("valid early", d[8], 32'h0);
      end
    end
    e = 8'(s >>> 3);
    cyc(2);
    rchk("estimate", IDX_STRENGTH, {16'h0, 8'he0, e});
    bus(1'b0, IDX_AUX, 32'h0, d);
    chk("valid", d[8], 32'h1);
    wr(IDX_STRENGTH, {e + 8'd1, 8'h55});
    cyc(3);
    chk("clear below", clear_channel, 32'h1);
    rchk("threshold rw", IDX_STRENGTH, {16'h0, e + 8'd1, e});
    wr(IDX_STRENGTH, {e, 8'h00});
    cyc(3);
    chk("clear at threshold", clear_channel, 32'h0);
    rx_enabled <= 1'b0;
    cyc(3);
    rchk("estimate off", IDX_STRENGTH, {16'h0, e, 8'h80});
    $display("strength test done");
    for (int r = 0; r < 2; r++) begin
      slow <= r[0];
      c = 16'($random(seed));
      c[7:4] = 4'hf;
      pl = 4'($random(seed)) & 4'h3;
      wr(IDX_SYNC, c);
      wr(IDX_AUX, {12'h0, pl});
      partner.got.delete();
      n = n_done;
      tx_start <= 1'b1;
      cyc(1);
      tx_start <= 1'b0;
      for (int k = 0; k < 400 && n_done == n; k++) cyc(1);
      chk("sync done", n_done - n, 32'h1);
      if (n_done == n) tally_and_finish();
      q.delete();
      repeat (2 * (pl + 1)) q.push_back(4'h0);
      for (int b = 0; b < 4; b++) begin
        nib = c[4*b +: 4];
        q.push_back(nib == 4'hf ? 4'h0 : nib);
      end
      chk("symbol count", partner.got.size(), q.size());
      foreach (q[j]) chk("symbol", partner.got[j], q[j]);
    end
    $display("transmit test done");
    wr(IDX_SYNC, 16'ha70f);
    correlator_value <= 5'd31;
    cyc(3);
    for (int j = 0; j < 4; j++) begin
      n = n_sync;
      for (int m = 4; m >= 0; m--) partner.send(seqs[j][4*m +: 4]);
      cyc(3);
      chk("sync found", n_sync - n, j == 0);
    end
    // Top nibble all ones: last symbol is free
    wr(IDX_SYNC, 16'hf70f);
    cyc(2);
    n = n_sync;
    d = 32'h00050073;
    for (int m = 4; m >= 0; m--) partner.send(d[4*m +: 4]);
    cyc(3);
    chk("wildcard sync", n_sync - n, 32'h1);
    $display("receive test done");
    tally_and_finish();
  end
endmodule : modem_cca_sync_config_test

// ### testbench/modem_side_model.sv
// Behavioural modem symbol side: takes transmit symbols, supplies receive symbols
`timescale 1ns/1ns
module modem_side_model (
  input  wire logic       ref_clk,
  input  wire logic       slow,
  input  wire logic [3:0] tx_sym,
  input  wire logic       tx_sym_valid,
  output logic            tx_sym_ack,
  output logic            rx_sym_valid,
  output logic [3:0]      rx_sym
);
  logic [3:0] got[$];
  int         wait_n = 0;
  int         seed   = 32'h5a5a;

  initial begin
    tx_sym_ack   = 1'b0;
    rx_sym_valid = 1'b0;
    rx_sym       = 4'h5;
  end

  // Random stalls when slow, so a symbol must stand until acked
  always @(posedge ref_clk) begin
    if (tx_sym_ack) begin
      tx_sym_ack <= 1'b0;
    end else if (tx_sym_valid === 1'b1) begin
      if (wait_n > 0) begin
        wait_n <= wait_n - 1;
      end else begin
        got.push_back(tx_sym);
        tx_sym_ack <= 1'b1;
        wait_n     <= slow ? ($unsigned($random(seed)) % 4) : 0;
      end
    end
  end

  // Idle lines show the inverse of the last symbol, never a stale copy
  task automatic send(input logic [3:0] s);
    @(posedge ref_clk);
    rx_sym_valid <= 1'b1;
    rx_sym       <= s;
    @(posedge ref_clk);
    rx_sym_valid <= 1'b0;
    rx_sym       <= ~s;
  endtask : send
endmodule : modem_side_model
